// *** rtl/ubc_regs.vh ***
// register map, field positions, reset values and timing counts
`ifndef UBC_REGS_VH
`define UBC_REGS_VH

// ---------------------------------------------------------------------------
// bus geometry
// ---------------------------------------------------------------------------
`define UBC_ADDR_W          17       // byte address width, index times four
`define UBC_IDX_W           15       // word index width
`define UBC_RESP_OKAY       2'b00    // axi okay answer
`define UBC_RESP_SLVERR     2'b10    // answer to an unmapped index

// ---------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------------------
`define UBC_IDX_DIV_LOW     15'h0000 // baud_divisor_low
`define UBC_IDX_DIV_HIGH    15'h0001 // baud_divisor_high
`define UBC_IDX_LINE_CTRL   15'h0003 // holds divisor latch access bit
`define UBC_IDX_SCRATCH     15'h0007 // scratch_storage
`define UBC_IDX_ACTIVATION  15'h4330 // block_activation
`define UBC_IDX_PIN_CTRL    15'h43f0 // serial_clock_pin_control

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define UBC_LC_DIVISOR_LATCH_ACCESS_BIT_BIT     7        // divisor latch access bit
`define UBC_ACT_BIT         0        // block activate
`define UBC_PC_SRC_BIT      0        // reference source select
`define UBC_PC_POWER_BIT    1        // power control, keep at zero
`define UBC_PC_POL_BIT      2        // pin polarity inversion
`define UBC_PC_EXT_BIT      3        // external reference select
`define UBC_PC_MASK         8'h0f    // writable bits of the pin control
`define UBC_ACT_MASK        8'h01    // writable bits of the activation

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define UBC_RST_DIV_LOW     8'h00
`define UBC_RST_DIV_HIGH    8'h00
`define UBC_RST_LINE_CTRL   8'h00
`define UBC_RST_SCRATCH     8'h00
`define UBC_RST_ACTIVATION  8'h00
`define UBC_RST_PIN_CTRL    8'h00

// ---------------------------------------------------------------------------
// internal reference: 1.8432 MHz out of 125 MHz is 1152 / 78125
// ---------------------------------------------------------------------------
`define UBC_INT_REF_STEP    17'h00480 // 1152
`define UBC_INT_REF_MOD     17'h1312d // 78125

`endif

// *** rtl/ubc_axil_slave.v ***
// axi4-lite slave front end: handshakes, address capture and responses
`include "ubc_regs.vh"
module ubc_axil_slave (
  input  wire                    aclk,
  input  wire                    aresetn,
  input  wire [`UBC_ADDR_W-1:0]  s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output reg                     s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output reg                     s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [`UBC_ADDR_W-1:0]  s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output reg                     s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  output reg                     wr_en,
  output reg  [`UBC_IDX_W-1:0]   wr_idx,
  output reg  [7:0]              wr_data,
  output reg                     wr_lane0,
  input  wire                    wr_hit,
  output reg  [`UBC_IDX_W-1:0]   rd_idx,
  input  wire [7:0]              rd_data,
  input  wire                    rd_hit
);

  reg aw_held;   // write address taken, waiting for the pair
  reg w_held;    // write data taken, waiting for the pair
  reg rd_pend;   // read index captured, data one cycle later

  // -------------------------------------------------------------------------
  // write channel: address and data in either order, then one response
  // -------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UBC_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_en         <= 1'b0;
      wr_idx        <= {`UBC_IDX_W{1'b0}};
      wr_data       <= 8'h00;
      wr_lane0      <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      // address taken; ready drops until the response is accepted
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_idx        <= s_axi_awaddr[`UBC_ADDR_W-1:2];
      end
      // only lane 0 carries register data, the upper lanes are ignored
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data      <= s_axi_wdata[7:0];
        wr_lane0     <= s_axi_wstrb[0];
      end
      // both halves present: commit and answer in the same edge
      if (aw_held && w_held && !s_axi_bvalid) begin
        wr_en        <= 1'b1;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `UBC_RESP_OKAY : `UBC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // read channel: capture index, answer one cycle later from the map
  // -------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `UBC_RESP_OKAY;
      rd_pend       <= 1'b0;
      rd_idx        <= {`UBC_IDX_W{1'b0}};
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        rd_pend       <= 1'b1;
        rd_idx        <= s_axi_araddr[`UBC_ADDR_W-1:2];
      end
      if (rd_pend) begin
        rd_pend      <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_data};
        s_axi_rresp  <= rd_hit ? `UBC_RESP_OKAY : `UBC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // ubc_axil_slave

// *** rtl/ubc_baud_gen.v ***
// divides reference ticks by the 16-bit divisor into the 16x baud enable
module ubc_baud_gen (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        run,       // block active
  input  wire        ref_tick,  // one aclk pulse per reference cycle
  input  wire [15:0] divisor,
  output reg         baud_out,  // generator output level
  output reg         baud_en    // one-cycle enable per baud output cycle
);

  reg  [15:0] count;                         // reference cycles seen
  wire        div_one  = (divisor == 16'h0001);
  wire        div_zero = (divisor == 16'h0000);
  wire [15:0] last     = divisor - 16'h0001; // terminal count
  wire        wrap     = (count >= last);    // also catches a shrunk divisor

  // -------------------------------------------------------------------------
  // counter and output
  // -------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn || !run || div_zero) begin
      // zero divisor lies outside the range: no enables at all
      count    <= 16'h0000;
      baud_out <= 1'b0;
      baud_en  <= 1'b0;
    end else if (div_one) begin
      // divide by one: level stays high, every reference cycle enables
      count    <= 16'h0000;
      baud_out <= 1'b1;
      baud_en  <= ref_tick;
    end else begin
      baud_en <= ref_tick && wrap;
      if (ref_tick) begin
        count    <= wrap ? 16'h0000 : count + 16'h0001;
        baud_out <= wrap;
      end
    end
  end

endmodule // ubc_baud_gen

// *** rtl/ubc_top.v ***
// baud generator and configuration registers of the serial port
//
// Decided for this implementation: the AXI4-Lite slave port.
`include "ubc_regs.vh"

// ---------------------------------------------------------------------------
// overview
// ---------------------------------------------------------------------------
// the block holds the divisor, scratch, pin control and activation
// registers behind an axi4-lite slave.  a reference tick is picked out
// of three sources and divided into the 16x baud enable, which feeds
// the shift logic outside.  the serial pins pass through here so their
// sense can be flipped.

// Operation
// - eight-bit scratch register, no side effects
// - divide selected reference by the divisor
// - divisor low and high bytes, reset zero
// - divisor writes only while latch access set
// - divisor one keeps generator output high
// - control bit 3 picks 24 or 16 MHz
// - control bit 2 inverts transmit and receive
// - control bit 0 set picks external, clear picks internal 1.8432 MHz
// - activation bit 0 enables reference, generator and pins; registers stay writable
module ubc_top (
  input  wire                    aclk,
  input  wire                    aresetn,
  // axi4-lite register port
  input  wire [`UBC_ADDR_W-1:0]  s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output wire                    s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output wire                    s_axi_wready,
  output wire [1:0]              s_axi_bresp,
  output wire                    s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [`UBC_ADDR_W-1:0]  s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output wire                    s_axi_arready,
  output wire [31:0]             s_axi_rdata,
  output wire [1:0]              s_axi_rresp,
  output wire                    s_axi_rvalid,
  input  wire                    s_axi_rready,
  // external reference ticks, one aclk pulse per reference cycle
  input  wire                    ext_ref_24m_tick,
  input  wire                    ext_ref_16m_tick,
  // serial side
  input  wire                    core_tx_data,
  output reg                     uart_tx,
  input  wire                    uart_rx,
  output reg                     core_rx_data,
  // generator and configuration outputs toward the shift logic
  output wire                    baud_out,
  output wire                    baud_en,
  output reg                     block_active,
  output reg                     divisor_latch_access_bit
);

  // -------------------------------------------------------------------------
  // register storage
  // -------------------------------------------------------------------------
  reg  [7:0]             baud_divisor_low;         // divisor bits 7:0
  reg  [7:0]             baud_divisor_high;        // divisor bits 15:8
  reg  [6:0]             line_control_rest;        // other line ctrl bits
  reg  [7:0]             scratch_storage;          // free for software
  reg  [7:0]             serial_clock_pin_control; // source and polarity

  // -------------------------------------------------------------------------
  // bus side wires
  // -------------------------------------------------------------------------
  wire                   wr_en;     // one-cycle commit of a write
  wire [`UBC_IDX_W-1:0]  wr_idx;    // word index of the write
  wire [7:0]             wr_data;   // lane 0 of the write data
  wire                   wr_lane0;  // lane 0 strobe
  wire [`UBC_IDX_W-1:0]  rd_idx;    // word index of the read
  reg                    wr_hit;    // write index is mapped
  reg                    rd_hit;    // read index is mapped
  reg  [7:0]             rd_data;   // read data for the captured index
  wire                   wr_go;     // write that actually stores

  // -------------------------------------------------------------------------
  // reference selection wires
  // -------------------------------------------------------------------------
  reg  [16:0]            int_acc;   // fractional accumulator
  reg                    int_tick;  // internal 1.8432 MHz tick
  reg                    ref_tick;  // selected reference tick
  wire [16:0]            acc_sum;   // accumulator plus step
  wire                   ext_pick;  // chosen external tick
  wire [15:0]            divisor;   // full divisor

  // line control reset value, split into the latch bit and the rest
  localparam [7:0]       lc_rst_value = `UBC_RST_LINE_CTRL;

  // -------------------------------------------------------------------------
  // bus slave
  // -------------------------------------------------------------------------
  ubc_axil_slave u_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_idx        (wr_idx),
    .wr_data       (wr_data),
    .wr_lane0      (wr_lane0),
    .wr_hit        (wr_hit),
    .rd_idx        (rd_idx),
    .rd_data       (rd_data),
    .rd_hit        (rd_hit)
  );

  // only a committed write with lane 0 enabled changes a register
  assign wr_go = wr_en && wr_lane0;

  // -------------------------------------------------------------------------
  // write address decode
  // -------------------------------------------------------------------------
  always @* begin
    if (wr_idx == `UBC_IDX_DIV_LOW) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `UBC_IDX_DIV_HIGH) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `UBC_IDX_LINE_CTRL) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `UBC_IDX_SCRATCH) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `UBC_IDX_ACTIVATION) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `UBC_IDX_PIN_CTRL) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;    // unmapped: answered with slverr
    end
  end

  // -------------------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------------------
  // registers stay writable while the block is inactive, otherwise
  // software could never set the activate bit in the first place
  always @(posedge aclk) begin
    if (!aresetn) begin
      baud_divisor_low         <= `UBC_RST_DIV_LOW;
      baud_divisor_high        <= `UBC_RST_DIV_HIGH;
      divisor_latch_access_bit <= lc_rst_value[`UBC_LC_DIVISOR_LATCH_ACCESS_BIT_BIT];
      line_control_rest        <= lc_rst_value[6:0];
      scratch_storage          <= `UBC_RST_SCRATCH;
      block_active             <= 1'b0;
      serial_clock_pin_control <= `UBC_RST_PIN_CTRL;
    end else if (wr_go) begin
      if (wr_idx == `UBC_IDX_DIV_LOW) begin
        // divisor bytes ignore writes while the latch bit is clear
        if (divisor_latch_access_bit) begin
          baud_divisor_low <= wr_data;
        end
      end else if (wr_idx == `UBC_IDX_DIV_HIGH) begin
        if (divisor_latch_access_bit) begin
          baud_divisor_high <= wr_data;
        end
      end else if (wr_idx == `UBC_IDX_LINE_CTRL) begin
        divisor_latch_access_bit <= wr_data[`UBC_LC_DIVISOR_LATCH_ACCESS_BIT_BIT];
        line_control_rest        <= wr_data[6:0];
      end else if (wr_idx == `UBC_IDX_SCRATCH) begin
        // plain storage, wired to nothing else
        scratch_storage <= wr_data;
      end else if (wr_idx == `UBC_IDX_ACTIVATION) begin
        block_active <= wr_data[`UBC_ACT_BIT];
      end else if (wr_idx == `UBC_IDX_PIN_CTRL) begin
        // power bit is stored as written; nothing here acts on it
        serial_clock_pin_control <= wr_data & `UBC_PC_MASK;
      end
    end
  end

  // -------------------------------------------------------------------------
  // read decode
  // -------------------------------------------------------------------------
  // reads have no side effects; reserved bits come back as zero
  always @* begin
    rd_hit  = 1'b1;
    rd_data = 8'h00;
    if (rd_idx == `UBC_IDX_DIV_LOW) begin
      rd_data = baud_divisor_low;
    end else if (rd_idx == `UBC_IDX_DIV_HIGH) begin
      rd_data = baud_divisor_high;
    end else if (rd_idx == `UBC_IDX_LINE_CTRL) begin
      rd_data = {divisor_latch_access_bit, line_control_rest};
    end else if (rd_idx == `UBC_IDX_SCRATCH) begin
      rd_data = scratch_storage;
    end else if (rd_idx == `UBC_IDX_ACTIVATION) begin
      rd_data = {7'h00, block_active} & `UBC_ACT_MASK;
    end else if (rd_idx == `UBC_IDX_PIN_CTRL) begin
      rd_data = serial_clock_pin_control & `UBC_PC_MASK;
    end else begin
      rd_hit = 1'b0;    // unmapped: zero data with slverr
    end
  end

  // -------------------------------------------------------------------------
  // internal reference tick
  // -------------------------------------------------------------------------
  // a fractional accumulator gives 1152 ticks per 78125 clocks, which
  // averages 1.8432 MHz exactly; single ticks jitter by one clock
  assign acc_sum = int_acc + `UBC_INT_REF_STEP;

  always @(posedge aclk) begin
    if (!aresetn || !block_active) begin
      int_acc  <= 17'h00000;
      int_tick <= 1'b0;
    end else if (acc_sum >= `UBC_INT_REF_MOD) begin
      int_acc  <= acc_sum - `UBC_INT_REF_MOD;
      int_tick <= 1'b1;
    end else begin
      int_acc  <= acc_sum;
      int_tick <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // reference source selection
  // -------------------------------------------------------------------------
  // a source change mid-count shifts the next baud edge by a fraction
  // of a reference cycle; software changes it while the port is idle
  assign ext_pick = serial_clock_pin_control[`UBC_PC_EXT_BIT] ?
                    ext_ref_16m_tick : ext_ref_24m_tick;

  always @(posedge aclk) begin
    if (!aresetn || !block_active) begin
      ref_tick <= 1'b0;
    end else if (serial_clock_pin_control[`UBC_PC_SRC_BIT]) begin
      ref_tick <= ext_pick;
    end else begin
      ref_tick <= int_tick;
    end
  end

  // -------------------------------------------------------------------------
  // baud generator
  // -------------------------------------------------------------------------
  // the divisor is not double buffered: a new byte acts on the next
  // reference tick, so a half-written divisor is briefly live
  assign divisor = {baud_divisor_high, baud_divisor_low};

  ubc_baud_gen u_baud (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (block_active),
    .ref_tick (ref_tick),
    .divisor  (divisor),
    .baud_out (baud_out),
    .baud_en  (baud_en)
  );

  // -------------------------------------------------------------------------
  // serial pins
  // -------------------------------------------------------------------------
  // while inactive the line idles at mark, in the selected sense, so
  // the far end sees no false start bit
  always @(posedge aclk) begin
    if (!aresetn) begin
      uart_tx      <= 1'b1;
      core_rx_data <= 1'b1;
    end else if (!block_active) begin
      uart_tx      <= ~serial_clock_pin_control[`UBC_PC_POL_BIT];
      core_rx_data <= 1'b1;
    end else begin
      uart_tx      <= core_tx_data ^
                      serial_clock_pin_control[`UBC_PC_POL_BIT];
      core_rx_data <= uart_rx ^
                      serial_clock_pin_control[`UBC_PC_POL_BIT];
    end
  end

endmodule // ubc_top

// *** tb/ubc_top_asserts.sv ***
// port-level checks of the baud and configuration block
module ubc_top_asserts (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        core_tx_data,
  input wire        uart_tx,
  input wire        uart_rx,
  input wire        core_rx_data,
  input wire        baud_out,
  input wire        baud_en,
  input wire        block_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write channels taken on one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // active long enough for the pin registers to settle
  sequence settled;
    block_active && $past(block_active) && $past(block_active, 2);
  endsequence
  b_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("new write taken early");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2
    s_axi_rvalid) else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  r_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  en_level_a: assert property (baud_en |-> baud_out)
    else $error("enable without output high");
  idle_gen_a: assert property (!block_active && $past(!block_active) |->
    !baud_en && !baud_out) else $error("generator runs while idle");
  pin_sense_a: assert property (settled |-> (uart_tx ^ $past(core_tx_data))
    == (core_rx_data ^ $past(uart_rx))) else $error("pin sense differs");
endmodule // ubc_top_asserts

bind ubc_top ubc_top_asserts chk (.*);

// *** tb/ubc_peer.sv ***
// remote serial peer: hears the transmit line and echoes it back
module ubc_peer (
  input  wire  aclk,
  input  wire  line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line_out = 1'b1;
  // one-cycle loopback keeps both pin directions exercised
  always @(posedge aclk) line_out <= line_in;
endmodule // ubc_peer

// *** tb/uart_baud_and_config_tb.sv ***
// self-checking bench for the baud and configuration block
`include "ubc_regs.vh"
module uart_baud_and_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, on24;
  logic s_axi_arvalid, s_axi_rready, core_tx_data, on16, ext_ref_24m_tick;
  logic ext_ref_16m_tick, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, uart_tx, uart_rx, core_rx_data;
  logic baud_out, baud_en, block_active, divisor_latch_access_bit;
  logic [16:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] rv;
  integer err_count, tests_run, cyc, ens, e;
  localparam [14:0] LO = `UBC_IDX_DIV_LOW, HI = `UBC_IDX_DIV_HIGH;
  localparam [14:0] LC = `UBC_IDX_LINE_CTRL, SC = `UBC_IDX_SCRATCH;
  localparam [14:0] AC = `UBC_IDX_ACTIVATION, PC = `UBC_IDX_PIN_CTRL;
  ubc_top DUT (.*);
  ubc_peer peer (.aclk(aclk), .line_in(uart_tx), .line_out(uart_rx));
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  // reference ticks: 24m every 4 cycles, 16m every 8; enable count; timeout
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    ext_ref_24m_tick <= on24 && cyc[1:0] == 2'h0;
    ext_ref_16m_tick <= on16 && cyc[2:0] == 3'h0;
    if (baud_en === 1'b1) ens <= ens + 1;
    if (cyc == 30000) begin
      err_count = err_count + 1;
      complete_run;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input [14:0] ix, input [7:0] d);
    reg a, w;
    @(posedge aclk);
    a = 0;
    w = 0;
    s_axi_awaddr <= {ix, 2'b00};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(a && w)) begin
      @(posedge aclk);
      if (s_axi_awready && !a) s_axi_awvalid <= 0;
      if (s_axi_wready && !w) s_axi_wvalid <= 0;
      a = a | s_axi_awready;
      w = w | s_axi_wready;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input [14:0] ix);
    @(posedge aclk);
    s_axi_araddr <= {ix, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    rv = s_axi_rdata[7:0];
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task cnt(input integer n);
    // let an enable launched before the last write drain first
    repeat (2) @(posedge aclk);
    e = ens;
    repeat (n) @(posedge aclk);
    e = ens - e;
  endtask
  task t_regs;
    rd(LO); chk(rv, 0);
    rd(HI); chk(rv, 0);
    rd(AC); chk(rv, 0);
    wr(SC, 8'ha5); rd(SC); chk(rv, 8'ha5);
    wr(LO, 8'h03); rd(LO); chk(rv, 0);
    wr(PC, 8'hf5); rd(PC); chk(rv, 8'h05);
    wr(AC, 8'hff); rd(AC); chk(rv, 1);
    chk(block_active, 1);
    rd(15'h0002); chk(rsp, `UBC_RESP_SLVERR);
    wr(15'h0002, 8'h11);
    chk(rsp, `UBC_RESP_SLVERR);
    wr(SC, 8'h5a);
    chk(rsp, `UBC_RESP_OKAY);
  endtask
  task t_baud;
    wr(LC, 8'h80);
    @(posedge aclk);
    chk(divisor_latch_access_bit, 1);
    wr(LO, 8'h03); rd(LO); chk(rv, 3);
    wr(PC, 8'h01); on24 <= 1; cnt(400); chk(e >= 33 && e <= 34, 1);
    wr(PC, 8'h09); on16 <= 1; cnt(800); chk(e >= 33 && e <= 34, 1);
    wr(LO, 8'h01); repeat (20) @(posedge aclk);
    repeat (16) @(posedge aclk) chk(baud_out, 1);
    wr(LO, 8'h00); cnt(200); chk(e, 0);
    wr(HI, 8'h01); cnt(4200); chk(e, 2);
    wr(PC, 8'h00); wr(LO, 8'h01); wr(HI, 8'h00);
    cnt(6250); chk(e >= 92 && e <= 93, 1);
  endtask
  task t_pins(input [7:0] pc);
    integer v;
    wr(PC, pc);
    for (v = 0; v < 2; v++) begin
      core_tx_data <= v[0];
      repeat (4) @(posedge aclk);
      chk(uart_tx, v[0] ^ pc[2]);
      chk(core_rx_data, v[0]);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    {s_axi_rready, core_tx_data, on24, on16, aresetn} = 0;
    {ext_ref_24m_tick, ext_ref_16m_tick} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    s_axi_wstrb = 4'hf;
    {cyc, ens, err_count, tests_run} = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    t_regs;
    t_baud;
    t_pins(8'h04);
    t_pins(8'h00);
    wr(AC, 8'h00); cnt(200); chk(e, 0);
    chk(uart_tx, 1);
    complete_run;
  end
endmodule // uart_baud_and_config_tb
